// [rtl/ranging_defs.vh]
/*
 Constants for the ranging sensor settings block: register offsets,
 field codes, reset values and timing figures. Included by bare name.
*/
`ifndef RANGING_DEFS_VH
`define RANGING_DEFS_VH

`define CLK_MHZ            50
`define CLK_PERIOD_NS      20

// Register offsets
`define REG_PULSE_LIMIT    8'h13
`define REG_MEDIAN         8'h3F
`define REG_SYMM_THRESH    8'h2F
`define REG_MAX_DIST       8'h35
`define REG_COVER_EN       8'h8F
`define REG_ACCUM          8'hA8
`define REG_STANDBY        8'hE8
`define REG_SOFT_RESET     8'hEE
`define REG_MEAS_COUNT     8'hF0

// Reset values
`define RST_PULSE_LIMIT    3'h0
`define RST_ACCUM          2'h3
`define RST_MEDIAN         2'h0
`define RST_COVER_EN       2'h3
`define RST_SYMM_THRESH    8'h0E
`define RST_MAX_DIST       8'h40
`define RST_ADDR_SEL       4'h8
`define SOFT_RESET_KEY     8'h06

// Pulse width limit codes 0..4 and their widths in microseconds
`define PW_CODE_MAX        3'h4
`define PW_US_0            320
`define PW_US_1            240
`define PW_US_2            160
`define PW_US_3            80
`define PW_US_4            40

// Accumulation codes and pulse counts
`define ACC_CODE_1         2'h0
`define ACC_CODE_5         2'h1
`define ACC_CODE_30        2'h2
`define ACC_CODE_10        2'h3
`define ACC_N_1            5'h01
`define ACC_N_5            5'h05
`define ACC_N_10           5'h0A
`define ACC_N_30           5'h1E

// One pulse slot; N slots make one measurement period (1.9, 9.5, 19, 57 ms)
`define SLOT_US            1900

`endif

// [rtl/i2c_reg_slave.v]
/*
 I2C slave byte engine with 7-bit address match, register pointer,
 auto-incrementing write and read bursts.
 Assumes scl and sda are already synchronous to clock and that scl is
 far slower than clock (400 kHz against 50 MHz).
*/
`timescale 1ns/100ps
module i2c_reg_slave (
  input  wire       clock,
  input  wire       rst_n,
  input  wire [6:0] dev_addr,
  input  wire       scl_i,
  input  wire       sda_i,
  output reg        sda_o,
  output reg        sda_oe,
  output reg  [7:0] ptr_q,
  input  wire [7:0] rd_data,
  output reg        wr_stb,
  output reg  [7:0] wr_addr,
  output reg  [7:0] wr_data
);
  localparam S_IDLE = 3'h0;
  localparam S_ADDR = 3'h1;
  localparam S_AACK = 3'h2;
  localparam S_WR   = 3'h3;
  localparam S_WACK = 3'h4;
  localparam S_RD   = 3'h5;
  localparam S_RACK = 3'h6;

  reg [2:0] st_q;
  reg [3:0] cnt_q;
  reg [7:0] sh_q;
  reg       scl_q;
  reg       sda_q;
  reg       rw_q;
  reg       first_q;
  reg       nack_q;

  wire scl_rise = scl_i & ~scl_q;
  wire scl_fall = ~scl_i & scl_q;
  wire start    = scl_i & scl_q & sda_q & ~sda_i;
  wire stop     = scl_i & scl_q & ~sda_q & sda_i;

  always @(posedge clock) begin
    if (!rst_n) begin
      st_q    <= S_IDLE;
      cnt_q   <= 4'h0;
      sh_q    <= 8'h00;
      scl_q   <= 1'b1;
      sda_q   <= 1'b1;
      rw_q    <= 1'b0;
      first_q <= 1'b0;
      nack_q  <= 1'b0;
      sda_o   <= 1'b0;
      sda_oe  <= 1'b0;
      ptr_q   <= 8'h00;
      wr_stb  <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 8'h00;
    end else begin
      scl_q  <= scl_i;
      sda_q  <= sda_i;
      wr_stb <= 1'b0;
      if (start) begin
        st_q    <= S_ADDR;
        cnt_q   <= 4'h0;
        first_q <= 1'b1;
        sda_oe  <= 1'b0;
      end else if (stop) begin
        st_q   <= S_IDLE;
        sda_oe <= 1'b0;
      end else begin
        case (st_q)
          S_ADDR, S_WR: begin
            if (scl_rise) begin
              sh_q  <= {sh_q[6:0], sda_i};
              cnt_q <= cnt_q + 4'h1;
            end else if (scl_fall && cnt_q == 4'h8) begin
              if (st_q == S_ADDR) begin
                if (sh_q[7:1] == dev_addr) begin
                  rw_q   <= sh_q[0];
                  sda_oe <= 1'b1;
                  st_q   <= S_AACK;
                end else begin
                  st_q <= S_IDLE;
                end
              end else begin
                sda_oe <= 1'b1;
                st_q   <= S_WACK;
                if (first_q) begin
                  ptr_q   <= sh_q;
                  first_q <= 1'b0;
                end else begin
                  wr_stb  <= 1'b1;
                  wr_addr <= ptr_q;
                  wr_data <= sh_q;
                  ptr_q   <= ptr_q + 8'h01;
                end
              end
            end
          end
          S_AACK: begin
            if (scl_fall) begin
              cnt_q <= 4'h0;
              if (rw_q) begin
                sh_q   <= rd_data;
                sda_oe <= ~rd_data[7];
                st_q   <= S_RD;
              end else begin
                sda_oe <= 1'b0;
                st_q   <= S_WR;
              end
            end
          end
          S_WACK: begin
            if (scl_fall) begin
              sda_oe <= 1'b0;
              cnt_q  <= 4'h0;
              st_q   <= S_WR;
            end
          end
          S_RD: begin
            if (scl_rise) begin
              cnt_q <= cnt_q + 4'h1;
            end else if (scl_fall) begin
              if (cnt_q == 4'h8) begin
                sda_oe <= 1'b0;
                ptr_q  <= ptr_q + 8'h01;
                st_q   <= S_RACK;
              end else begin
                sh_q   <= {sh_q[6:0], 1'b0};
                sda_oe <= ~sh_q[6];
              end
            end
          end
          S_RACK: begin
            if (scl_rise) begin
              nack_q <= sda_i;
            end else if (scl_fall) begin
              if (nack_q) begin
                st_q <= S_IDLE;
              end else begin
                sh_q   <= rd_data;
                sda_oe <= ~rd_data[7];
                cnt_q  <= 4'h0;
                st_q   <= S_RD;
              end
            end
          end
          default: begin
            st_q   <= S_IDLE;
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end
endmodule

// [rtl/ranging_sensor_settings.v]
/*
 Settings and measurement pacing of a ranging sensor: I2C register
 file, fuse-loaded power-up configuration and the emitter pulse /
 accumulation sequencer.
 Assumes fuse contents are stable inputs and that the host keeps to
 normal I2C framing on synchronous scl/sda samples.
 // Function
 // - Act as I2C slave, 7-bit address, up to 400 kHz, registers writable.
 // - Fuse-stored settings are applied as the configuration after each power-up.
 // - Slave address comes only from fuses; default write 0x80, read 0x81.
 // - Sixteen addresses, write byte 0x00..0xF0 step 0x10, read adds bit 0.
 // - Emitter pulse width follows signal intensity, never above the limit.
 // - Limit choices 320/240/160/80/40 us, default 320, fuse and I2C settable.
 // - Lowering the limit keeps response time; only pulse energy drops.
 // - Accumulate 1, 5, 10 or 30 pulses, default 10, then compute.
 // - Periods about 1.9/9.5/19/57 ms for the four accumulation counts.
 // - Median, cover compensation, error threshold, max distance I2C configurable.
 // - Accumulation code 0=1, 1=5, 2=30, 3=10; reset code 3.
*/
`timescale 1ns/100ps
`include "ranging_defs.vh"
module ranging_sensor_settings #(
  parameter SLOT_CYC   = `SLOT_US * `CLK_MHZ,
  parameter PW_MAX_CYC = `PW_US_0 * `CLK_MHZ
) (
  input  wire       clock,
  input  wire       rst_n,
  input  wire       scl_i,
  input  wire       sda_i,
  output wire       sda_o,
  output wire       sda_oe,
  input  wire       fuse_valid,
  input  wire [3:0] fuse_addr_sel,
  input  wire [2:0] fuse_pulse_limit,
  input  wire [1:0] fuse_accum,
  input  wire [1:0] intensity_level,
  output reg        emitter_on,
  output reg        measure_done,
  output reg  [1:0] median_code,
  output reg  [1:0] cover_enable,
  output reg  [7:0] symm_threshold,
  output reg  [7:0] max_distance
);
  reg [3:0]  addr_sel_q;
  reg [2:0]  pulse_lim_q;
  reg [1:0]  accum_q;
  reg        standby_q;
  reg        load_q;
  reg [7:0]  meas_cnt_q;
  reg [23:0] slot_cnt_q;
  reg [23:0] width_q;
  reg [4:0]  pulse_idx_q;
  reg [7:0]  rd_data;

  wire [7:0] ptr;
  wire       wr_stb;
  wire [7:0] wr_addr;
  wire [7:0] wr_data;

  function [4:0] accum_n;
    input [1:0] code;
    begin
      case (code)
        `ACC_CODE_1:  accum_n = `ACC_N_1;
        `ACC_CODE_5:  accum_n = `ACC_N_5;
        `ACC_CODE_30: accum_n = `ACC_N_30;
        default:      accum_n = `ACC_N_10;
      endcase
    end
  endfunction

  // limit code to cycles, scaled from the 320 us figure
  function [23:0] width_of;
    input [2:0] code;
    reg   [31:0] us;
    reg   [31:0] cyc;
    begin
      case (code)
        3'h0:    us = `PW_US_0;
        3'h1:    us = `PW_US_1;
        3'h2:    us = `PW_US_2;
        3'h3:    us = `PW_US_3;
        default: us = `PW_US_4;
      endcase
      cyc      = PW_MAX_CYC * us / `PW_US_0;
      width_of = cyc[23:0];
    end
  endfunction

  // fuse limit code, default when unprogrammed or out of range
  function [2:0] fuse_limit;
    input       valid;
    input [2:0] code;
    begin
      if (valid && code <= `PW_CODE_MAX) begin
        fuse_limit = code;
      end else begin
        fuse_limit = `RST_PULSE_LIMIT;
      end
    end
  endfunction

  // address only from fuses; select picks 0x00..0xF0 write byte
  i2c_reg_slave u_slave (
    .clock    (clock),
    .rst_n    (rst_n),
    .dev_addr ({addr_sel_q, 3'h0}),
    .scl_i    (scl_i),
    .sda_i    (sda_i),
    .sda_o    (sda_o),
    .sda_oe   (sda_oe),
    .ptr_q    (ptr),
    .rd_data  (rd_data),
    .wr_stb   (wr_stb),
    .wr_addr  (wr_addr),
    .wr_data  (wr_data)
  );

  always @* begin
    case (ptr)
      `REG_PULSE_LIMIT: rd_data = {5'h00, pulse_lim_q};
      `REG_ACCUM:       rd_data = {6'h00, accum_q};
      `REG_MEDIAN:      rd_data = {6'h00, median_code};
      `REG_COVER_EN:    rd_data = {6'h00, cover_enable};
      `REG_SYMM_THRESH: rd_data = symm_threshold;
      `REG_MAX_DIST:    rd_data = max_distance;
      `REG_STANDBY:     rd_data = {7'h00, standby_q};
      `REG_MEAS_COUNT:  rd_data = meas_cnt_q;
      default:          rd_data = 8'h00;
    endcase
  end

  // Register file; fuse image loaded in the first cycle after reset
  // Bus writes in that cycle are dropped; no host is that quick
  always @(posedge clock) begin
    if (!rst_n) begin
      load_q         <= 1'b1;
      addr_sel_q     <= `RST_ADDR_SEL;
      pulse_lim_q    <= `RST_PULSE_LIMIT;
      accum_q        <= `RST_ACCUM;
      median_code    <= `RST_MEDIAN;
      cover_enable   <= `RST_COVER_EN;
      symm_threshold <= `RST_SYMM_THRESH;
      max_distance   <= `RST_MAX_DIST;
      standby_q      <= 1'b0;
    end else if (load_q) begin
      load_q <= 1'b0;
      // fuse settings become the starting configuration
      pulse_lim_q <= fuse_limit(fuse_valid, fuse_pulse_limit);
      if (fuse_valid) begin
        addr_sel_q <= fuse_addr_sel;
        accum_q    <= fuse_accum;
      end
    end else if (wr_stb) begin
      // downstream settings writable over the bus
      case (wr_addr)
        `REG_PULSE_LIMIT: begin
          if (wr_data[2:0] <= `PW_CODE_MAX && wr_data[7:3] == 5'h00) begin
            pulse_lim_q <= wr_data[2:0];
          end
        end
        `REG_ACCUM:       accum_q <= wr_data[1:0];
        `REG_MEDIAN:      median_code <= wr_data[1:0];
        `REG_COVER_EN:    cover_enable <= wr_data[1:0];
        `REG_SYMM_THRESH: symm_threshold <= wr_data;
        `REG_MAX_DIST:    max_distance <= wr_data;
        `REG_STANDBY:     standby_q <= wr_data[0];
        `REG_SOFT_RESET: begin
          // fuse limit and accumulation reapplied in place, address select kept; the slot timing keeps
          // running, so a soft reset never restarts an emitter slot
          if (wr_data == `SOFT_RESET_KEY) begin
            pulse_lim_q    <= fuse_limit(fuse_valid, fuse_pulse_limit);
            accum_q        <= fuse_valid ? fuse_accum : `RST_ACCUM;
            median_code    <= `RST_MEDIAN;
            cover_enable   <= `RST_COVER_EN;
            symm_threshold <= `RST_SYMM_THRESH;
            max_distance   <= `RST_MAX_DIST;
            standby_q      <= 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Measurement sequencer. Slot length never depends on pulse width,
  // so a shorter limit only trims energy per pulse.
  always @(posedge clock) begin
    if (!rst_n || standby_q || load_q) begin
      slot_cnt_q   <= 24'h000000;
      pulse_idx_q  <= 5'h00;
      width_q      <= 24'h000000;
      emitter_on   <= 1'b0;
      measure_done <= 1'b0;
      if (!rst_n) begin
        meas_cnt_q <= 8'h00;
      end
    end else begin
      measure_done <= 1'b0;
      if (slot_cnt_q == 24'h000000) begin
        // stronger return shortens the pulse below the limit
        width_q    <= width_of(pulse_lim_q) >> intensity_level;
        emitter_on <= 1'b1;
      end else if (slot_cnt_q >= width_q) begin
        emitter_on <= 1'b0;
      end
      // slot timing fixed regardless of limit
      if (slot_cnt_q == SLOT_CYC[23:0] - 24'h000001) begin
        slot_cnt_q <= 24'h000000;
        // compute after N accumulated pulses; period is N slots
        if (pulse_idx_q >= accum_n(accum_q) - 5'h01) begin
          pulse_idx_q  <= 5'h00;
          measure_done <= 1'b1;
          meas_cnt_q   <= meas_cnt_q + 8'h01;
        end else begin
          pulse_idx_q <= pulse_idx_q + 5'h01;
        end
      end else begin
        slot_cnt_q <= slot_cnt_q + 24'h000001;
      end
    end
  end
endmodule

// [tb/ranging_checks_assertions.sv]
/*
 Port checker for the ranging settings block.
 Bound to the design top; sees its ports only.
*/
`timescale 1ns/100ps
module ranging_checks #(
  parameter SLOT_CYC   = 40,
  parameter PW_MAX_CYC = 16
) (
  input wire       clock,
  input wire       rst_n,
  input wire       scl_i,
  input wire       sda_o,
  input wire       sda_oe,
  input wire       emitter_on,
  input wire       measure_done,
  input wire [1:0] median_code,
  input wire [1:0] cover_enable,
  input wire [7:0] symm_threshold,
  input wire [7:0] max_distance
);
  reg [15:0] run_q;
  reg [15:0] gap_q;
  reg [15:0] rise_q;
  reg        em_q;
  reg        done_seen_q;
  reg        rise_seen_q;

  default clocking cb @(posedge clock); endclocking

  always @(posedge clock) begin
    if (!rst_n) begin
      run_q       <= 16'h0000;
      gap_q       <= 16'h0000;
      rise_q      <= 16'h0000;
      em_q        <= 1'h0;
      done_seen_q <= 1'h0;
      rise_seen_q <= 1'h0;
    end else begin
      run_q       <= emitter_on ? run_q + 16'h0001 : 16'h0000;
      gap_q       <= measure_done ? 16'h0001 : gap_q + 16'h0001;
      rise_q      <= (emitter_on && !em_q) ? 16'h0001 : rise_q + 16'h0001;
      em_q        <= emitter_on;
      done_seen_q <= done_seen_q | measure_done;
      rise_seen_q <= rise_seen_q | (emitter_on && !em_q);
    end
  end

  a_sda_o_low: assert property (disable iff (!rst_n) sda_o == 1'h0)
    else $error("sda driven high");
  a_reset_defaults: assert property (!rst_n |=> median_code == 2'h0 && cover_enable == 2'h3
    && symm_threshold == 8'h0E && max_distance == 8'h40) else $error("settings not at defaults");
  a_reset_quiet: assert property (!rst_n |=> !emitter_on && !measure_done && !sda_oe)
    else $error("activity during reset");
  a_done_one_cycle: assert property (disable iff (!rst_n) measure_done |=> !measure_done)
    else $error("measure_done longer than one cycle");
  a_done_spacing: assert property (disable iff (!rst_n) measure_done && done_seen_q |-> gap_q >= SLOT_CYC)
    else $error("measurements too close");
  a_emit_width_cap: assert property (disable iff (!rst_n) run_q <= PW_MAX_CYC)
    else $error("emitter pulse above limit");
  a_emit_period: assert property (disable iff (!rst_n) emitter_on && !em_q && rise_seen_q |-> rise_q >= SLOT_CYC)
    else $error("emitter pulses too close");
  a_ack_scl_low: assert property (disable iff (!rst_n) $changed(sda_oe) |-> !scl_i && !$past(scl_i))
    else $error("sda changed with scl high");
  a_settings_scl_low: assert property (disable iff (!rst_n)
    $changed({median_code, cover_enable, symm_threshold, max_distance}) |-> !scl_i) else $error("setting changed");

  c_measure: cover property (measure_done);
  c_ack: cover property ($rose(sda_oe));
  c_short_pulse: cover property (emitter_on && run_q == 16'h0004);
endmodule

bind ranging_sensor_settings ranging_checks #(.SLOT_CYC(SLOT_CYC), .PW_MAX_CYC(PW_MAX_CYC)) u_checks (
  .clock(clock), .rst_n(rst_n), .scl_i(scl_i), .sda_o(sda_o), .sda_oe(sda_oe), .emitter_on(emitter_on),
  .measure_done(measure_done), .median_code(median_code), .cover_enable(cover_enable),
  .symm_threshold(symm_threshold), .max_distance(max_distance));

// [tb/i2c_host_model.sv]
/*
 I2C bus master model driving scl and an open-drain sda.
 Assumes a pull-up resolves sda outside this model.
*/
`timescale 1ns/100ps
module i2c_host_model #(
  parameter Q = 6
) (
  input  wire       clock,
  output reg        scl,
  output reg        sda_drv,
  input  wire       sda_line
);
  reg a0;
  reg a1;
  reg a2;
  integer k;

  initial begin
    scl = 1'h1;
    sda_drv = 1'h1;
  end

  task tick(input integer n);
    repeat (n) @(negedge clock);
  endtask

  // bus rate compressed to keep the run short
  task put_bit(input reg b);
    begin
      sda_drv = b;
      tick(Q);
      scl = 1'h1;
      tick(2 * Q);
      scl = 1'h0;
      tick(Q);
    end
  endtask

  task get_bit(output reg b);
    begin
      sda_drv = 1'h1;
      tick(Q);
      scl = 1'h1;
      tick(Q);
      b = sda_line;
      tick(Q);
      scl = 1'h0;
      tick(Q);
    end
  endtask

  task start_cond;
    begin
      sda_drv = 1'h1;
      tick(Q);
      scl = 1'h1;
      tick(2 * Q);
      sda_drv = 1'h0;
      tick(2 * Q);
      scl = 1'h0;
      tick(Q);
    end
  endtask

  task stop_cond;
    begin
      sda_drv = 1'h0;
      tick(Q);
      scl = 1'h1;
      tick(2 * Q);
      sda_drv = 1'h1;
      tick(2 * Q);
    end
  endtask

  task put_byte(input [7:0] d, output reg ack);
    begin
      for (k = 7; k >= 0; k = k - 1) put_bit(d[k]);
      get_bit(ack);
      ack = !ack;
    end
  endtask

  // Single-byte read, closed with a NACK
  task get_byte(output [7:0] d);
    begin
      for (k = 7; k >= 0; k = k - 1) get_bit(d[k]);
      put_bit(1'h1);
    end
  endtask

  task write_reg(input [7:0] dev, input [7:0] ptr, input [7:0] dat, output reg ok);
    begin
      start_cond;
      put_byte(dev, a0);
      put_byte(ptr, a1);
      put_byte(dat, a2);
      stop_cond;
      ok = a0 & a1 & a2;
    end
  endtask

  task read_reg(input [7:0] dev, input [7:0] ptr, output [7:0] dat, output reg ok);
    begin
      start_cond;
      put_byte(dev, a0);
      put_byte(ptr, a1);
      start_cond;
      put_byte(dev | 8'h01, a2);
      get_byte(dat);
      stop_cond;
      ok = a0 & a1 & a2;
    end
  endtask
endmodule

// [tb/test_ranging_sensor_settings.sv]
/*
 Testbench for the ranging settings block.
 Assumes the I2C host model and the bound checker are compiled.
*/
`timescale 1ns/100ps
module test_ranging_sensor_settings;
  localparam SLOT = 40;
  localparam PW = 16;
  reg        clock = 1'h0;
  reg        rst_n = 1'h0;
  reg        fuse_valid = 1'h0;
  reg  [3:0] fuse_addr_sel = 4'h0;
  reg  [2:0] fuse_pulse_limit = 3'h0;
  reg  [1:0] fuse_accum = 2'h0;
  reg  [1:0] intensity_level = 2'h0;
  wire       scl, sda_drv, sda_o, sda_oe, emitter_on, measure_done;
  wire [1:0] median_code, cover_enable;
  wire [7:0] symm_threshold, max_distance;
  wire       sda = sda_drv & (sda_oe ? sda_o : 1'h1);
  reg  [7:0] rd;
  reg        ok;
  integer    err_count = 0, checks = 0, cycles = 0, n, w, p, i;

  always #10 clock = ~clock;

  ranging_sensor_settings #(.SLOT_CYC(SLOT), .PW_MAX_CYC(PW)) dut (
    .clock(clock), .rst_n(rst_n), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
    .fuse_valid(fuse_valid), .fuse_addr_sel(fuse_addr_sel), .fuse_pulse_limit(fuse_pulse_limit),
    .fuse_accum(fuse_accum), .intensity_level(intensity_level), .emitter_on(emitter_on),
    .measure_done(measure_done), .median_code(median_code), .cover_enable(cover_enable),
    .symm_threshold(symm_threshold), .max_distance(max_distance));

  i2c_host_model host (.clock(clock), .scl(scl), .sda_drv(sda_drv), .sda_line(sda));

  task finish_test;
    begin
      $display("checks %0d err_count %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask

  task check(input [31:0] got, input [31:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask

  always @(posedge clock) begin
    cycles = cycles + 1;
    if (cycles == 80000) begin
      err_count = err_count + 1;
      finish_test;
    end
  end

  task do_reset;
    begin
      rst_n = 1'h0;
      repeat (20) @(negedge clock);
      rst_n = 1'h1;
      repeat (2) @(negedge clock);
    end
  endtask

  task wr(input [7:0] dev, input [7:0] ptr, input [7:0] dat, input reg ack);
    begin
      host.write_reg(dev, ptr, dat, ok);
      check(ok, ack);
    end
  endtask

  task rdchk(input [7:0] dev, input [7:0] ptr, input [7:0] exp);
    begin
      host.read_reg(dev, ptr, rd, ok);
      check(ok, 1);
      check(rd, exp);
    end
  endtask

  // Gap to the next done pulse, minus one
  task wait_done;
    begin
      n = 0;
      @(negedge clock);
      while (measure_done !== 1'h1 && n < 5000) begin
        @(negedge clock);
        n = n + 1;
      end
    end
  endtask

  // Width of the next emitter pulse and rise-to-rise period
  task emit_meas;
    begin
      while (emitter_on) @(negedge clock);
      while (!emitter_on) @(negedge clock);
      w = 0;
      while (emitter_on) begin
        @(negedge clock);
        w = w + 1;
      end
      p = w;
      while (!emitter_on) begin
        @(negedge clock);
        p = p + 1;
      end
    end
  endtask

  function integer acc_n(input integer c);
    acc_n = (c == 0) ? 1 : (c == 1) ? 5 : (c == 2) ? 30 : 10;
  endfunction

  function integer pw_exp(input integer c);
    pw_exp = PW * ((c == 4) ? 40 : 320 - 80 * c) / 320;
  endfunction

  initial begin
    do_reset;
    check({median_code, cover_enable, symm_threshold, max_distance}, 20'h30E40);
    rdchk(8'h80, 8'hA8, 8'h03);
    rdchk(8'h80, 8'h13, 8'h00);
    wr(8'h80, 8'h2F, 8'h21, 1'h1);
    check(symm_threshold, 8'h21);
    wr(8'h90, 8'h2F, 8'h55, 1'h0);
    check(symm_threshold, 8'h21);
    wr(8'h80, 8'hEE, 8'h06, 1'h1);
    check(symm_threshold, 8'h0E);
    wr(8'h80, 8'h3F, 8'h02, 1'h1);
    wr(8'h80, 8'h8F, 8'h02, 1'h1);
    wr(8'h80, 8'h35, 8'h20, 1'h1);
    check({median_code, cover_enable, max_distance}, 12'hA20);
    wr(8'h80, 8'hE8, 8'h01, 1'h1);
    rdchk(8'h80, 8'hE8, 8'h01);
    n = 0;
    repeat (2 * SLOT) begin
      @(negedge clock);
      n = n + emitter_on;
    end
    check(n, 0);
    wr(8'h80, 8'hE8, 8'h00, 1'h1);
    for (i = 0; i < 4; i = i + 1) begin
      wr(8'h80, 8'hA8, i[7:0], 1'h1);
      wait_done;
      wait_done;
      check(n + 1, acc_n(i) * SLOT);
    end
    // Code 5 is out of range and must leave code 4 in force
    for (i = 0; i < 6; i = i + 1) begin
      wr(8'h80, 8'h13, i[7:0], 1'h1);
      emit_meas;
      check(w, pw_exp(i > 4 ? 4 : i));
      check(p, SLOT);
    end
    wr(8'h80, 8'h13, 8'h00, 1'h1);
    for (i = 1; i < 4; i = i + 1) begin
      intensity_level = i[1:0];
      emit_meas;
      check(w, PW >> i);
    end
    fuse_valid = 1'h1;
    fuse_pulse_limit = 3'h2;
    fuse_accum = 2'h1;
    intensity_level = 2'h0;
    for (i = 0; i < 16; i = i + 1) begin
      fuse_addr_sel = i[3:0];
      do_reset;
      rdchk({i[3:0], 4'h0}, 8'hA8, 8'h01);
    end
    wr(8'h80, 8'h2F, 8'h33, 1'h0);
    rdchk(8'hF0, 8'h13, 8'h02);
    emit_meas;
    check(w, PW / 2);
    wait_done;
    wait_done;
    check(n + 1, 5 * SLOT);
    finish_test;
  end
endmodule
